/* slh_pkg.sv */
// Constants for the strap, LED and host signal pin block, plus its pin synchroniser.
// Assumes one 20 MHz system clock and an Avalon-MM master for the register bus.
//
// Summary of operation
// - Each LED pin is driven low to light and high to darken.
// - Global control bit 9 picks speed plus link/activity, or activity plus link.
// - Activity LEDs blink during traffic; link LEDs stay lit while link is up.
// - Speed LED is lit at 100 Mb/s and dark at 10 Mb/s.
// - First LED pin level is latched at reset as 16-bit or 8-bit bus width.
// - Wake output asserts on a wake event, polarity set in software, default low.
// - Interrupt pin only drives low while an unmasked status bit is set; pull-up returns high.
// - EEPROM data pin level is latched at reset as EEPROM present or absent.
// - EEPROM clock pin level is latched at reset as big or little endian.
// - Device makes the EEPROM clock: 4 us at speed field 11, 800 ns at 00.
// - A dedicated select output picks the EEPROM while software holds EEPROM control bit 0 set.

package slh_pkg;
  // Clock
  localparam int unsigned CLK_PERIOD_NS = 50;

  // Register byte offsets
  localparam logic [4:0] REG_GLOBAL_CTRL = 5'h00;
  localparam logic [4:0] REG_BUS_SPEED = 5'h04;
  localparam logic [4:0] REG_WAKE_CTRL = 5'h08;
  localparam logic [4:0] REG_STATUS = 5'h0C;
  localparam logic [4:0] REG_MASK = 5'h10;
  localparam logic [4:0] REG_STRAP = 5'h14;
  localparam logic [4:0] REG_EEPROM = 5'h18;

  // Field positions
  localparam int unsigned GC_LED_MODE_BIT = 9;
  localparam int unsigned WK_POL_BIT = 0;
  localparam int unsigned ST_WAKE_BIT = 0;
  localparam int unsigned ST_LINK_BIT = 1;
  localparam int unsigned ST_READ_BIT = 2;
  localparam int unsigned ST_WRITE_BIT = 3;
  localparam int unsigned STATUS_W = 4;
  localparam int unsigned EE_SEL_BIT = 0;
  localparam int unsigned EE_RUN_BIT = 1;
  localparam int unsigned EE_DOUT_BIT = 2;
  localparam int unsigned EE_DOE_BIT = 3;
  localparam int unsigned EE_DIN_BIT = 4;
  localparam int unsigned EE_CTRL_W = 4;

  // Reset values
  localparam logic [31:0] GLOBAL_CTRL_RST = 32'h0000_0000;
  localparam logic [1:0] BUS_SPEED_RST = 2'h3;
  localparam logic [1:0] BUS_SPEED_FAST = 2'h0;
  localparam logic WAKE_POL_RST = 1'b0;
  localparam logic [STATUS_W-1:0] MASK_RST = 4'h0;
  localparam logic [EE_CTRL_W-1:0] EE_CTRL_RST = 4'h0;

  // Pin synchroniser bit positions
  localparam int unsigned SY_LED1 = 0;
  localparam int unsigned SY_EED = 1;
  localparam int unsigned SY_EEPROM_SERIAL_CLK = 2;
  localparam int unsigned SY_IRQ = 3;
  localparam int unsigned SY_RD = 4;
  localparam int unsigned SY_WR = 5;
  localparam int unsigned SY_W = 6;

  // Strap capture waits for the synchroniser to fill
  localparam logic [1:0] STRAP_WAIT_CYC = 2'h3;

  // EEPROM serial clock: half period in cycles, derived from the printed period
  localparam int unsigned EEPROM_SERIAL_CLK_SLOW_NS = 4000;
  localparam int unsigned EEPROM_SERIAL_CLK_FAST_NS = 800;
  localparam logic [6:0] EEPROM_SERIAL_CLK_SLOW_HALF = 7'(EEPROM_SERIAL_CLK_SLOW_NS / (2 * CLK_PERIOD_NS));
  localparam logic [6:0] EEPROM_SERIAL_CLK_FAST_HALF = 7'(EEPROM_SERIAL_CLK_FAST_NS / (2 * CLK_PERIOD_NS));

  // LED blink half period and activity hold
  localparam int unsigned BLINK_HALF_US = 50000;
  localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_US * 1000 / CLK_PERIOD_NS;
  localparam logic [1:0] ACT_HOLD_TICKS = 2'h2;
endpackage

`timescale 1ns/10ps
// Two-flop synchroniser for asynchronous pin inputs
module slh_sync #(
  parameter int unsigned W = 1
) (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // Pull-up idle level chosen so strobes read inactive during reset
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_q <= '1;
      sync_q <= '1;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;
endmodule

/* slh_top.sv */
// Pin logic: port LEDs, reset straps, wake and interrupt pins, host strobes, EEPROM clock.
// Assumes pins are asynchronous, MAC status inputs share i_sys_clk, Avalon-MM master.
`timescale 1ns/10ps
module slh_top
  import slh_pkg::*;
#(
  parameter int unsigned P_BLINK_CYC = BLINK_HALF_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  // Avalon-MM slave
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // MAC / PHY status, same clock
  input wire logic i_link_up,
  input wire logic i_speed_100,
  input wire logic i_activity,
  input wire logic i_wake_event,
  // LED pins
  input wire logic i_port_led_first,
  output logic o_port_led_first,
  output logic o_port_led_first_oe,
  output logic o_port_led_second,
  // Host pins
  output logic o_wake_event_out,
  input wire logic i_host_irq_n,
  output logic o_host_irq_n,
  output logic o_host_irq_n_oe,
  input wire logic i_host_read_strobe_n,
  input wire logic i_host_write_strobe_n,
  output logic o_host_read_active,
  output logic o_host_write_active,
  // EEPROM pins
  input wire logic i_eeprom_data_io,
  output logic o_eeprom_data_io,
  output logic o_eeprom_data_io_oe,
  input wire logic i_eeprom_serial_clk,
  output logic o_eeprom_serial_clk,
  output logic o_eeprom_serial_clk_oe,
  output logic o_eeprom_select,
  // Latched straps
  output logic o_bus_16bit,
  output logic o_eeprom_present,
  output logic o_big_endian,
  // Interrupt
  output logic o_irq
);

  if (P_BLINK_CYC < 2 || P_BLINK_CYC > (1 << 20)) begin : g_bad_blink
    $error("P_BLINK_CYC must lie in 2 .. 2**20");
  end

  // Merge write data into a register under Avalon byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Pin synchronisers
  logic [SY_W-1:0] pins_s;
  slh_sync #(
    .W(SY_W)
  ) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_async({i_host_write_strobe_n, i_host_read_strobe_n, i_host_irq_n,
              i_eeprom_serial_clk, i_eeprom_data_io, i_port_led_first}),
    .o_sync(pins_s)
  );

  // ---------------- Strap capture ----------------
  logic [1:0] strap_cnt_q, strap_cnt_d;
  logic strap_done_q, strap_done_d;
  logic bus16_q, bus16_d;
  logic ee_pres_q, ee_pres_d;
  logic big_end_q, big_end_d;

  // Capture once after the synchroniser has filled with post-reset pin levels
  always_comb begin
    strap_cnt_d = strap_cnt_q;
    strap_done_d = strap_done_q;
    bus16_d = bus16_q;
    ee_pres_d = ee_pres_q;
    big_end_d = big_end_q;
    if (!strap_done_q) begin
      if (strap_cnt_q == STRAP_WAIT_CYC) begin
        strap_done_d = 1'b1;
        bus16_d = pins_s[SY_LED1];
        ee_pres_d = pins_s[SY_EED];
        big_end_d = pins_s[SY_EEPROM_SERIAL_CLK];
      end else begin
        strap_cnt_d = strap_cnt_q + 2'h1;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      strap_cnt_q <= 2'h0;
      strap_done_q <= 1'b0;
      bus16_q <= 1'b0;
      ee_pres_q <= 1'b0;
      big_end_q <= 1'b0;
    end else begin
      strap_cnt_q <= strap_cnt_d;
      strap_done_q <= strap_done_d;
      bus16_q <= bus16_d;
      ee_pres_q <= ee_pres_d;
      big_end_q <= big_end_d;
    end
  end

  // ---------------- Register file ----------------
  logic [31:0] gctrl_q, gctrl_d;
  logic [1:0] bspeed_q, bspeed_d;
  logic wk_pol_q, wk_pol_d;
  logic [STATUS_W-1:0] status_q, status_d;
  logic [STATUS_W-1:0] mask_q, mask_d;
  logic [EE_CTRL_W-1:0] ee_ctrl_q, ee_ctrl_d;
  logic ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic link_prev_q, rd_prev_q, wr_prev_q;
  logic [STATUS_W-1:0] events;
  logic wr_hit;
  logic [31:0] wmerge;

  // Hardware events that set sticky status bits
  assign events[ST_WAKE_BIT] = i_wake_event;
  assign events[ST_LINK_BIT] = i_link_up ^ link_prev_q;
  assign events[ST_READ_BIT] = rd_prev_q & ~pins_s[SY_RD];
  assign events[ST_WRITE_BIT] = wr_prev_q & ~pins_s[SY_WR];

  // One wait state: the answer comes at the second edge of a request
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_q;
  assign wr_hit = i_avs_write & ack_q; // Commit at the edge where waitrequest reads low

  // Register next state; a hardware set beats a same-cycle software clear
  always_comb begin
    gctrl_d = gctrl_q;
    bspeed_d = bspeed_q;
    wk_pol_d = wk_pol_q;
    mask_d = mask_q;
    ee_ctrl_d = ee_ctrl_q;
    status_d = status_q;
    rdata_d = rdata_q;
    ack_d = (i_avs_read | i_avs_write) & ~ack_q;
    wmerge = 32'h0000_0000;
    if (wr_hit) begin
      case (i_avs_address)
        REG_GLOBAL_CTRL: begin
          gctrl_d = be_merge(gctrl_q, i_avs_writedata, i_avs_byteenable);
        end
        REG_BUS_SPEED: begin
          wmerge = be_merge({30'h0, bspeed_q}, i_avs_writedata, i_avs_byteenable);
          bspeed_d = wmerge[1:0];
        end
        REG_WAKE_CTRL: begin
          wmerge = be_merge({31'h0, wk_pol_q}, i_avs_writedata, i_avs_byteenable);
          wk_pol_d = wmerge[WK_POL_BIT];
        end
        REG_STATUS: begin
          if (i_avs_byteenable[0]) begin
            status_d = status_q & ~i_avs_writedata[STATUS_W-1:0];
          end
        end
        REG_MASK: begin
          wmerge = be_merge({28'h0, mask_q}, i_avs_writedata, i_avs_byteenable);
          mask_d = wmerge[STATUS_W-1:0];
        end
        REG_EEPROM: begin
          wmerge = be_merge({28'h0, ee_ctrl_q}, i_avs_writedata, i_avs_byteenable);
          ee_ctrl_d = wmerge[EE_CTRL_W-1:0];
        end
        default: begin
          wmerge = 32'h0000_0000;
        end
      endcase
    end
    status_d = status_d | events;
    if (i_avs_read & ~ack_q) begin
      case (i_avs_address)
        REG_GLOBAL_CTRL: rdata_d = gctrl_q;
        REG_BUS_SPEED: rdata_d = {30'h0, bspeed_q};
        REG_WAKE_CTRL: rdata_d = {31'h0, wk_pol_q};
        REG_STATUS: rdata_d = {28'h0, status_q};
        REG_MASK: rdata_d = {28'h0, mask_q};
        REG_STRAP: rdata_d = {23'h0, ~pins_s[SY_WR], ~pins_s[SY_RD], pins_s[SY_IRQ],
                              i_speed_100, i_link_up, strap_done_q, big_end_q, ee_pres_q,
                              bus16_q};
        REG_EEPROM: rdata_d = {27'h0, pins_s[SY_EED], ee_ctrl_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      gctrl_q <= GLOBAL_CTRL_RST;
      bspeed_q <= BUS_SPEED_RST;
      wk_pol_q <= WAKE_POL_RST;
      status_q <= '0;
      mask_q <= MASK_RST;
      ee_ctrl_q <= EE_CTRL_RST;
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      link_prev_q <= 1'b0;
      rd_prev_q <= 1'b1;
      wr_prev_q <= 1'b1;
    end else begin
      gctrl_q <= gctrl_d;
      bspeed_q <= bspeed_d;
      wk_pol_q <= wk_pol_d;
      status_q <= status_d;
      mask_q <= mask_d;
      ee_ctrl_q <= ee_ctrl_d;
      ack_q <= ack_d;
      rdata_q <= rdata_d;
      link_prev_q <= i_link_up;
      rd_prev_q <= pins_s[SY_RD];
      wr_prev_q <= pins_s[SY_WR];
    end
  end

  assign o_avs_readdata = rdata_q;
  assign o_irq = |(status_q & mask_q);

  // ---------------- LED blink and activity hold ----------------
  logic [19:0] blink_cnt_q, blink_cnt_d;
  logic blink_q, blink_d;
  logic [1:0] act_hold_q, act_hold_d;
  logic blink_tick;
  logic act_on;

  assign blink_tick = (blink_cnt_q == 20'(P_BLINK_CYC - 1));
  assign act_on = (act_hold_q != 2'h0);

  // Hold keeps a short burst visible for a whole blink instead of a flicker
  always_comb begin
    blink_cnt_d = blink_tick ? 20'h0_0000 : blink_cnt_q + 20'h0_0001;
    blink_d = blink_tick ? ~blink_q : blink_q;
    act_hold_d = act_hold_q;
    if (i_activity) begin
      act_hold_d = ACT_HOLD_TICKS;
    end else if (blink_tick && act_on) begin
      act_hold_d = act_hold_q - 2'h1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      blink_cnt_q <= 20'h0_0000;
      blink_q <= 1'b0;
      act_hold_q <= 2'h0;
    end else begin
      blink_cnt_q <= blink_cnt_d;
      blink_q <= blink_d;
      act_hold_q <= act_hold_d;
    end
  end

  // ---------------- EEPROM serial clock ----------------
  logic [6:0] ee_div_q, ee_div_d;
  logic eeprom_serial_clk_q, eeprom_serial_clk_d;
  logic [6:0] ee_half;

  // Only field 00 selects the fast clock; every other field runs slow
  assign ee_half = (bspeed_q == BUS_SPEED_FAST) ? EEPROM_SERIAL_CLK_FAST_HALF : EEPROM_SERIAL_CLK_SLOW_HALF;

  always_comb begin
    ee_div_d = 7'h00;
    eeprom_serial_clk_d = 1'b0;
    if (ee_ctrl_q[EE_RUN_BIT] && strap_done_q) begin
      if (ee_div_q >= ee_half - 7'h01) begin
        eeprom_serial_clk_d = ~eeprom_serial_clk_q;
      end else begin
        ee_div_d = ee_div_q + 7'h01;
        eeprom_serial_clk_d = eeprom_serial_clk_q;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ee_div_q <= 7'h00;
      eeprom_serial_clk_q <= 1'b0;
    end else begin
      ee_div_q <= ee_div_d;
      eeprom_serial_clk_q <= eeprom_serial_clk_d;
    end
  end

  // ---------------- Pin outputs ----------------
  logic led_first_lit;
  logic led_second_lit;
  logic led_first_q, led_second_q, wake_q;

  // LED meaning chosen by the global control bit
  always_comb begin
    if (gctrl_q[GC_LED_MODE_BIT]) begin
      led_first_lit = act_on & blink_q;
      led_second_lit = i_link_up;
    end else begin
      led_first_lit = i_link_up & i_speed_100;
      led_second_lit = i_link_up & ~(act_on & blink_q);
    end
  end

  // Registered pins; LEDs are low when lit
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      led_first_q <= 1'b1;
      led_second_q <= 1'b1;
      wake_q <= 1'b1;
    end else begin
      led_first_q <= ~led_first_lit;
      led_second_q <= ~led_second_lit;
      wake_q <= status_q[ST_WAKE_BIT] ^ ~wk_pol_q;
    end
  end

  // Strap pins stay undriven until the straps are held
  assign o_port_led_first = led_first_q;
  assign o_port_led_first_oe = strap_done_q;
  assign o_port_led_second = led_second_q;
  assign o_wake_event_out = wake_q;
  assign o_host_irq_n = 1'b0;
  assign o_host_irq_n_oe = o_irq;
  assign o_host_read_active = ~pins_s[SY_RD];
  assign o_host_write_active = ~pins_s[SY_WR];
  assign o_eeprom_data_io = ee_ctrl_q[EE_DOUT_BIT];
  assign o_eeprom_data_io_oe = ee_ctrl_q[EE_DOE_BIT] & strap_done_q;
  assign o_eeprom_serial_clk = eeprom_serial_clk_q;
  assign o_eeprom_serial_clk_oe = strap_done_q;
  assign o_eeprom_select = ee_ctrl_q[EE_SEL_BIT];
  assign o_bus_16bit = bus16_q;
  assign o_eeprom_present = ee_pres_q;
  assign o_big_endian = big_end_q;
endmodule

/* slh_sva.sv */
// Checker for the pin block, bound to the top module's ports.
// Assumes one clock domain and an active low asynchronous reset.
`timescale 1ns/10ps
module slh_sva (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic o_avs_waitrequest,
  input wire logic i_link_up,
  input wire logic i_host_read_strobe_n,
  input wire logic i_host_write_strobe_n,
  input wire logic o_host_read_active,
  input wire logic o_host_write_active,
  input wire logic o_port_led_first_oe,
  input wire logic o_port_led_second,
  input wire logic o_host_irq_n,
  input wire logic o_host_irq_n_oe,
  input wire logic o_irq,
  input wire logic o_eeprom_serial_clk,
  input wire logic o_eeprom_serial_clk_oe,
  input wire logic o_bus_16bit,
  input wire logic o_eeprom_present,
  input wire logic o_big_endian
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  // Interrupt pin only ever pulls low
  chk_irq_drive_low: assert property (o_irq |-> o_host_irq_n_oe && !o_host_irq_n)
    else $error("irq pin not pulled low");
  chk_irq_pin_release: assert property (!o_irq |-> !o_host_irq_n_oe)
    else $error("irq pin driven while idle");
  // Straps frozen once the pins are handed back
  chk_strap_stable: assert property (o_port_led_first_oe
    |=> $stable({o_bus_16bit, o_eeprom_present, o_big_endian}))
    else $error("strap value moved");
  chk_strap_oe_pair: assert property (o_port_led_first_oe == o_eeprom_serial_clk_oe)
    else $error("strap pins released apart");
  // Strobe falls seen through the synchroniser
  chk_read_seen: assert property ($fell(i_host_read_strobe_n) |-> ##[1:4] o_host_read_active)
    else $error("read strobe missed");
  chk_write_seen: assert property ($fell(i_host_write_strobe_n)
    |-> ##[1:4] o_host_write_active)
    else $error("write strobe missed");
  // At most one wait state per access
  chk_wait_one: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
    |=> !o_avs_waitrequest)
    else $error("wait state count wrong");
  // High half period never shorter than the fast setting
  chk_eeprom_serial_clk_high: assert property ($rose(o_eeprom_serial_clk) |=> o_eeprom_serial_clk[*7])
    else $error("eeprom clock high too short");
  chk_led_no_link: assert property (o_port_led_first_oe && !$past(i_link_up)
    && !$past(i_link_up, 2) |-> o_port_led_second)
    else $error("link led lit without link");
endmodule

/* slh_pin_model.sv */
// Board around the pins: strap pulls, irq pull-up, host strobes.
// Assumes the bench sets pull levels and strobe requests.
`timescale 1ns/10ps
module slh_pin_model (
  input wire logic [2:0] i_pull,
  input wire logic i_rd_req,
  input wire logic i_wr_req,
  input wire logic i_led_out,
  input wire logic i_led_oe,
  input wire logic i_eed_out,
  input wire logic i_eed_oe,
  input wire logic i_eeprom_serial_clk_out,
  input wire logic i_eeprom_serial_clk_oe,
  input wire logic i_irq_out,
  input wire logic i_irq_oe,
  output logic o_led_pin,
  output logic o_eed_pin,
  output logic o_eeprom_serial_clk_pin,
  output logic o_irq_pin,
  output logic o_rd_n,
  output logic o_wr_n
);
  // Pull resistor wins while the pin floats
  assign o_led_pin = i_led_oe ? i_led_out : i_pull[0];
  assign o_eed_pin = i_eed_oe ? i_eed_out : i_pull[1];
  assign o_eeprom_serial_clk_pin = i_eeprom_serial_clk_oe ? i_eeprom_serial_clk_out : i_pull[2];
  assign o_irq_pin = i_irq_oe ? i_irq_out : 1'b1;
  // Host strobes, low while a cycle runs
  assign o_rd_n = !i_rd_req;
  assign o_wr_n = !i_wr_req;
endmodule

/* testbench.sv */
// Self-checking bench for the pin block.
// Assumes the board model and checker files are compiled first.
`timescale 1ns/10ps
module testbench;
  import slh_pkg::*;
  logic i_sys_clk = 0, i_resetn = 0, i_avs_read = 0, i_avs_write = 0;
  logic [4:0] i_avs_address = 0;
  logic [3:0] i_avs_byteenable = 4'hF;
  logic [31:0] i_avs_writedata = 0, o_avs_readdata, rdata;
  logic i_link_up = 0, i_speed_100 = 0, i_activity = 0, i_wake_event = 0;
  logic i_port_led_first, o_port_led_first, o_port_led_first_oe, o_port_led_second;
  logic o_wake_event_out, i_host_irq_n, o_host_irq_n, o_host_irq_n_oe, o_irq;
  logic i_host_read_strobe_n, i_host_write_strobe_n, o_host_read_active;
  logic o_host_write_active, i_eeprom_data_io, o_eeprom_data_io, o_eeprom_data_io_oe;
  logic i_eeprom_serial_clk, o_eeprom_serial_clk, o_eeprom_serial_clk_oe;
  logic o_eeprom_select, o_bus_16bit, o_eeprom_present, o_big_endian, o_avs_waitrequest;
  logic [2:0] pull = 0;
  logic rd_req = 0, wr_req = 0;
  int fail_count = 0, total_checks = 0, cyc = 0;

  slh_top #(.P_BLINK_CYC(4)) dut (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_byteenable(i_avs_byteenable), .i_avs_writedata(i_avs_writedata),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .i_link_up(i_link_up), .i_speed_100(i_speed_100), .i_activity(i_activity),
    .i_wake_event(i_wake_event), .i_port_led_first(i_port_led_first),
    .o_port_led_first(o_port_led_first), .o_port_led_first_oe(o_port_led_first_oe),
    .o_port_led_second(o_port_led_second), .o_wake_event_out(o_wake_event_out),
    .i_host_irq_n(i_host_irq_n), .o_host_irq_n(o_host_irq_n),
    .o_host_irq_n_oe(o_host_irq_n_oe),
    .i_host_read_strobe_n(i_host_read_strobe_n),
    .i_host_write_strobe_n(i_host_write_strobe_n),
    .o_host_read_active(o_host_read_active), .o_host_write_active(o_host_write_active),
    .i_eeprom_data_io(i_eeprom_data_io), .o_eeprom_data_io(o_eeprom_data_io),
    .o_eeprom_data_io_oe(o_eeprom_data_io_oe), .i_eeprom_serial_clk(i_eeprom_serial_clk),
    .o_eeprom_serial_clk(o_eeprom_serial_clk),
    .o_eeprom_serial_clk_oe(o_eeprom_serial_clk_oe),
    .o_eeprom_select(o_eeprom_select), .o_bus_16bit(o_bus_16bit),
    .o_eeprom_present(o_eeprom_present), .o_big_endian(o_big_endian), .o_irq(o_irq));
  slh_pin_model board (.i_pull(pull), .i_rd_req(rd_req), .i_wr_req(wr_req),
    .i_led_out(o_port_led_first), .i_led_oe(o_port_led_first_oe),
    .i_eed_out(o_eeprom_data_io), .i_eed_oe(o_eeprom_data_io_oe),
    .i_eeprom_serial_clk_out(o_eeprom_serial_clk), .i_eeprom_serial_clk_oe(o_eeprom_serial_clk_oe),
    .i_irq_out(o_host_irq_n), .i_irq_oe(o_host_irq_n_oe), .o_led_pin(i_port_led_first),
    .o_eed_pin(i_eeprom_data_io), .o_eeprom_serial_clk_pin(i_eeprom_serial_clk), .o_irq_pin(i_host_irq_n),
    .o_rd_n(i_host_read_strobe_n), .o_wr_n(i_host_write_strobe_n));

  // Free-running 20 MHz clock
  always #25 i_sys_clk = ~i_sys_clk;

  // Hang guard, well above the expected run
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Pin or flag comparison
  task automatic chk(input logic [31:0] a, input logic [31:0] e);
    total_checks++;
    if (a !== e) begin
      fail_count++;
      $display("[ERR] t=%0t got %h exp %h", $time, a, e);
    end
  endtask

  // One Avalon access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_write <= w;
    i_avs_read <= !w;
    do @(posedge i_sys_clk); while (o_avs_waitrequest !== 1'b0);
    rdata = o_avs_readdata;
    i_avs_write <= 0;
    i_avs_read <= 0;
  endtask

  // Register read comparison
  task automatic rdc(input logic [4:0] a, input logic [31:0] e);
    bus(0, a, 0);
    chk(rdata, e);
  endtask

  // Main sequence
  initial begin
    int m, k, n;
    logic [2:0] s;
    logic [31:0] d;
    time t0;
    void'($urandom(38));
    s = 3'($urandom);
    pull <= s;
    repeat (16) @(posedge i_sys_clk);
    i_resetn <= 1;
    repeat (6) @(posedge i_sys_clk);
    pull <= ~s;
    bus(1, REG_STRAP, 0);
    chk({o_bus_16bit, o_eeprom_present, o_big_endian}, {s[0], s[1], s[2]});
    chk({o_port_led_first_oe, o_eeprom_serial_clk_oe, o_eeprom_data_io_oe}, 3'b110);
    bus(0, REG_STRAP, 0);
    chk(rdata[3:0], {1'b1, s[2], s[1], s[0]});
    $display("test straps done");
    rdc(REG_GLOBAL_CTRL, 0);
    rdc(REG_BUS_SPEED, 3);
    rdc(REG_WAKE_CTRL, 0);
    rdc(REG_MASK, 0);
    rdc(5'h1C, 0);
    d = $urandom;
    bus(1, REG_GLOBAL_CTRL, d);
    rdc(REG_GLOBAL_CTRL, d);
    $display("test registers done");
    for (m = 0; m < 2; m++) begin
      bus(1, REG_GLOBAL_CTRL, 32'(m) << 9);
      for (k = 0; k < 4; k++) begin
        i_link_up <= k[0];
        i_speed_100 <= k[1];
        repeat (4) @(posedge i_sys_clk);
        chk(o_port_led_first, m ? 1 : !(k[0] && k[1]));
        chk(o_port_led_second, !k[0]);
      end
      n = 0;
      repeat (40) begin
        @(posedge i_sys_clk);
        i_activity <= 1;
        n += m ? !o_port_led_first : !o_port_led_second;
      end
      i_activity <= 0;
      chk(n > 4 && n < 36, 1);
      // Let the activity hold run out before the next mode is checked
      repeat (12) @(posedge i_sys_clk);
    end
    $display("test leds done");
    bus(1, REG_STATUS, 32'hF);
    for (m = 0; m < 2; m++) begin
      bus(1, REG_WAKE_CTRL, m);
      bus(1, REG_MASK, 1);
      @(posedge i_sys_clk) i_wake_event <= 1;
      @(posedge i_sys_clk) i_wake_event <= 0;
      repeat (3) @(posedge i_sys_clk);
      chk(o_wake_event_out, m);
      chk({o_irq, i_host_irq_n}, 2'b10);
      bus(1, REG_MASK, 0);
      repeat (2) @(posedge i_sys_clk);
      chk({o_irq, i_host_irq_n}, 2'b01);
      bus(1, REG_STATUS, 1);
      repeat (2) @(posedge i_sys_clk);
      chk(o_wake_event_out, !m);
    end
    $display("test wake irq done");
    for (m = 0; m < 2; m++) begin
      if (m) wr_req <= 1;
      else rd_req <= 1;
      repeat (5) @(posedge i_sys_clk);
      chk({o_host_write_active, o_host_read_active}, m ? 2'b10 : 2'b01);
      bus(0, REG_STATUS, 0);
      chk(rdata[2 + m], 1);
      rd_req <= 0;
      wr_req <= 0;
      repeat (4) @(posedge i_sys_clk);
      chk({o_host_write_active, o_host_read_active}, 2'b00);
    end
    $display("test strobes done");
    for (m = 0; m < 2; m++) begin
      bus(1, REG_BUS_SPEED, m ? 0 : 3);
      bus(1, REG_EEPROM, 3);
      @(posedge o_eeprom_serial_clk);
      t0 = $time;
      @(posedge o_eeprom_serial_clk);
      chk(32'(($time - t0) / 50), m ? 16 : 80);
      chk(o_eeprom_select, 1);
      @(negedge o_eeprom_serial_clk);
      bus(1, REG_EEPROM, 0);
      repeat (2) @(posedge i_sys_clk);
      chk(o_eeprom_select, 0);
    end
    // Data pin driven back through its own input once the strap is held
    bus(1, REG_EEPROM, 32'h0000_000C);
    repeat (3) @(posedge i_sys_clk);
    chk({o_eeprom_data_io_oe, o_eeprom_data_io}, 2'b11);
    rdc(REG_EEPROM, 32'h0000_001C);
    $display("test eeprom done");
    give_verdict();
  end
endmodule

bind slh_top slh_sva chk_i (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .o_avs_waitrequest(o_avs_waitrequest), .i_link_up(i_link_up),
  .i_host_read_strobe_n(i_host_read_strobe_n),
  .i_host_write_strobe_n(i_host_write_strobe_n),
  .o_host_read_active(o_host_read_active), .o_host_write_active(o_host_write_active),
  .o_port_led_first_oe(o_port_led_first_oe), .o_port_led_second(o_port_led_second),
  .o_host_irq_n(o_host_irq_n), .o_host_irq_n_oe(o_host_irq_n_oe), .o_irq(o_irq),
  .o_eeprom_serial_clk(o_eeprom_serial_clk),
  .o_eeprom_serial_clk_oe(o_eeprom_serial_clk_oe), .o_bus_16bit(o_bus_16bit),
  .o_eeprom_present(o_eeprom_present), .o_big_endian(o_big_endian));
